// ==== inc/mhx_cfg.svh ====
`ifndef MHX_CFG_SVH
`define MHX_CFG_SVH
`define MHX_ADDR_OPND 8'h00
`define MHX_ADDR_CMD 8'h04
`define MHX_ADDR_STAT 8'h08
`define MHX_ADDR_DREG 8'h0C
`define MHX_ADDR_ACC0_LO 8'h10
`define MHX_ADDR_ACC0_HI 8'h14
`define MHX_ADDR_ACC1_LO 8'h18
`define MHX_ADDR_ACC1_HI 8'h1C
`define MHX_CMD_MODE_LSB 0
`define MHX_CMD_MIXED 3
`define MHX_CMD_UNIT 4
`define MHX_CMD_OP_LSB 5
`define MHX_CMD_HALF 7
`define MHX_CMD_PAIR_LSB 8
`define MHX_PAIR_FORBIDDEN 2'h3
`define MHX_ST_RES_OV 0
`define MHX_ST_RES_STK 1
`define MHX_ST_ACC_OV0 2
`define MHX_ST_CMD_ERR 6
`define MHX_ST_RND 8
`define MHX_STAT_RESET 9'h000
`define MHX_FRAC_SPECIAL 16'h8000
`define MHX_FRAC_SAT 34'h0_7FFF_FFFF
`define MHX_RND_HALF 16'h8000
`endif

// ==== inc/mhx_pkg.sv ====
package mhx_pkg;
  typedef enum logic [2:0] {
    MHX_DEFAULT,
    MHX_TFU,
    MHX_SCALED_ROUNDED_FRAC_MODE,
    MHX_SCALED_SIGNED_INT_MODE,
    MHX_IH
  } mhx_mode_t;
  typedef enum logic [1:0] {
    MHX_OP_LOAD,
    MHX_OP_ADD,
    MHX_OP_SUB
  } mhx_op_t;
endpackage

// ==== inc/mhx_xt_if.sv ====
`timescale 1ns/1ps
interface mhx_xt_if;
  logic [39:0] acc;
  mhx_pkg::mhx_mode_t mode;
  logic unbiased;
  logic [15:0] half;
  logic sat;
  modport mac (output acc, output mode, output unbiased, input half, input sat);
  modport ext (input acc, input mode, input unbiased, output half, output sat);
endinterface

// ==== hw/mhx_extract.sv ====
`timescale 1ns/1ps
`include "mhx_cfg.svh"
module mhx_extract (
  mhx_xt_if.ext xt // Accumulator in, half word out
);
  logic signed [41:0] x;
  logic signed [42:0] r;
  logic signed [26:0] v;
  logic do_rnd;
  logic [15:0] inc;
  // Works on a copy only, so the accumulator is untouched
  always_comb begin
    x = {{2{xt.acc[39]}}, xt.acc};
    do_rnd = 1'b1;
    unique case (xt.mode)
      mhx_pkg::MHX_DEFAULT: x = {{2{xt.acc[39]}}, xt.acc};
      mhx_pkg::MHX_TFU: begin
        x = {2'b00, xt.acc};
        do_rnd = 1'b0;
      end
      mhx_pkg::MHX_SCALED_ROUNDED_FRAC_MODE: x = {xt.acc[39], xt.acc, 1'b0};
      mhx_pkg::MHX_SCALED_SIGNED_INT_MODE: begin
        x = {{9{xt.acc[15]}}, xt.acc[15:0], 17'h0_0000};
        do_rnd = 1'b0;
      end
      mhx_pkg::MHX_IH: x = {{2{xt.acc[39]}}, xt.acc};
      default: x = {{2{xt.acc[39]}}, xt.acc};
    endcase
  end
  // Unbiased: an exact half rounds toward the even result
  always_comb begin
    inc = 16'h0000;
    if (do_rnd) begin
      if (!(xt.unbiased && x[15:0] == `MHX_RND_HALF && !x[16])) begin
        inc = `MHX_RND_HALF;
      end
    end
  end
  assign r = {x[41], x} + {27'h000_0000, inc};
  assign v = r[42:16];
  always_comb begin
    xt.half = v[15:0];
    xt.sat = 1'b0;
    if (xt.mode == mhx_pkg::MHX_TFU) begin
      if (v > 27'sh000_FFFF) begin
        xt.half = 16'hFFFF;
        xt.sat = 1'b1;
      end
    end else if (v > 27'sh000_7FFF) begin
      xt.half = 16'h7FFF;
      xt.sat = 1'b1;
    end else if (v < -27'sh000_8000) begin
      xt.half = 16'h8000;
      xt.sat = 1'b1;
    end
  end
endmodule

// ==== hw/mhx_top.sv ====
`timescale 1ns/1ps
`include "mhx_cfg.svh"
module mhx_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys, // Core clock
  input wire logic reset, // Async reset, high
  input wire logic [ADDR_W-1:0] addr, // Byte address
  input wire logic [31:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  output logic [31:0] rd_data, // Read data, next cycle
  output logic [31:0] dreg_out, // Destination data register
  output logic done_pulse // Operation executed
);
  // Decode uses addr[7:0], so narrower buses cannot reach the map
  if (ADDR_W < 8) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  logic [31:0] rd_data_q;
  logic [31:0] dreg_q;
  logic done_q;
  logic [15:0] src0_q;
  logic [15:0] src1_q;
  logic res_ov_q;
  logic res_stk_q;
  logic cmd_err_q;
  logic rnd_bit_q;
  logic [39:0] acc_q [2];
  logic acc_ov_q [2];
  logic acc_stk_q [2];

  logic cmd_wr;
  logic [2:0] mode_raw;
  mhx_pkg::mhx_mode_t mode;
  logic mixed;
  logic unit;
  mhx_pkg::mhx_op_t op;
  logic [1:0] op_raw;
  logic half_hi;
  logic [1:0] pair;
  logic cmd_ok;
  logic a_signed;
  logic b_signed;
  logic frac_shift;
  logic special;
  logic signed [16:0] a17;
  logic signed [16:0] b17;
  logic signed [33:0] prod;
  logic signed [33:0] prod_c;
  logic signed [41:0] prod_x;
  logic signed [41:0] acc_x;
  logic signed [41:0] sum;
  logic signed [41:0] lim_lo;
  logic signed [41:0] lim_hi;
  logic signed [41:0] clamped;
  logic acc_sat;
  logic [39:0] acc_sel;
  logic [39:0] acc_new;

  mhx_xt_if xt ();

  assign cmd_wr = wr_en && addr[7:0] == `MHX_ADDR_CMD;
  assign mode_raw = wr_data[`MHX_CMD_MODE_LSB +: 3];
  assign mode = mhx_pkg::mhx_mode_t'(mode_raw);
  assign mixed = wr_data[`MHX_CMD_MIXED];
  assign unit = wr_data[`MHX_CMD_UNIT];
  assign op_raw = wr_data[`MHX_CMD_OP_LSB +: 2];
  assign op = mhx_pkg::mhx_op_t'(op_raw);
  assign half_hi = wr_data[`MHX_CMD_HALF];
  assign pair = wr_data[`MHX_CMD_PAIR_LSB +: 2];

  // Bad commands are dropped whole and only flag an error
  always_comb begin
    cmd_ok = 1'b1;
    if (mode_raw > 3'(mhx_pkg::MHX_IH)) begin
      cmd_ok = 1'b0;
    end
    if (op_raw == 2'h3) begin
      cmd_ok = 1'b0;
    end
    if (mixed && !unit) begin
      cmd_ok = 1'b0;
    end
    if (pair == `MHX_PAIR_FORBIDDEN) begin
      cmd_ok = 1'b0;
    end
  end

  // Operand signedness
  always_comb begin
    a_signed = 1'b1;
    b_signed = 1'b1;
    if (mixed) begin
      a_signed = 1'b1;
      b_signed = 1'b0;
    end else if (mode == mhx_pkg::MHX_TFU) begin
      a_signed = 1'b0;
      b_signed = 1'b0;
    end
  end

  assign a17 = {a_signed & src0_q[15], src0_q};
  assign b17 = {b_signed & src1_q[15], src1_q};
  assign prod = a17 * b17;

  // Only signed fraction modes get the one-bit shift correction
  always_comb begin
    frac_shift = 1'b0;
    if (!mixed) begin
      if (mode == mhx_pkg::MHX_DEFAULT || mode == mhx_pkg::MHX_SCALED_ROUNDED_FRAC_MODE) begin
        frac_shift = 1'b1;
      end
    end
  end

  assign special = frac_shift && src0_q == `MHX_FRAC_SPECIAL
    && src1_q == `MHX_FRAC_SPECIAL;

  always_comb begin
    prod_c = prod;
    if (special) begin
      prod_c = `MHX_FRAC_SAT;
    end else if (frac_shift) begin
      prod_c = prod <<< 1;
    end
  end

  // Unsigned products are non-negative, so sign extension zero-fills
  assign prod_x = {{8{prod_c[33]}}, prod_c};

  assign acc_sel = unit ? acc_q[1] : acc_q[0];

  always_comb begin
    if (mode == mhx_pkg::MHX_TFU) begin
      acc_x = {2'b00, acc_sel};
    end else begin
      acc_x = {{2{acc_sel[39]}}, acc_sel};
    end
  end

  // 42 bits hold any sum of a 40-bit value and a 34-bit product
  always_comb begin
    unique case (op)
      mhx_pkg::MHX_OP_LOAD: sum = prod_x;
      mhx_pkg::MHX_OP_ADD: sum = acc_x + prod_x;
      mhx_pkg::MHX_OP_SUB: sum = acc_x - prod_x;
      default: sum = prod_x;
    endcase
  end

  always_comb begin
    lim_lo = -42'sh080_0000_0000;
    lim_hi = 42'sh07F_FFFF_FFFF;
    unique case (mode)
      mhx_pkg::MHX_DEFAULT: lim_lo = -42'sh080_0000_0000;
      mhx_pkg::MHX_TFU: begin
        lim_lo = 42'sh000_0000_0000;
        lim_hi = 42'sh0FF_FFFF_FFFF;
      end
      mhx_pkg::MHX_SCALED_ROUNDED_FRAC_MODE: lim_lo = -42'sh080_0000_0000;
      mhx_pkg::MHX_SCALED_SIGNED_INT_MODE: lim_lo = -42'sh080_0000_0000;
      mhx_pkg::MHX_IH: begin
        lim_lo = -42'sh000_8000_0000;
        lim_hi = 42'sh000_7FFF_FFFF;
      end
      // Codes above 4 reach here between commands; they are refused anyway
      default: lim_lo = -42'sh080_0000_0000;
    endcase
  end

  // Special product counts as an accumulator saturation
  always_comb begin
    clamped = sum;
    acc_sat = special;
    if (sum > lim_hi) begin
      clamped = lim_hi;
      acc_sat = 1'b1;
    end else if (sum < lim_lo) begin
      clamped = lim_lo;
      acc_sat = 1'b1;
    end
  end

  assign acc_new = clamped[39:0];

  // Extraction sees the freshly written accumulator value
  assign xt.acc = acc_new;
  assign xt.mode = mode;
  assign xt.unbiased = rnd_bit_q;

  mhx_extract u_extract (
    .xt(xt.ext)
  );

  // Operand register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      src0_q <= 16'h0000;
      src1_q <= 16'h0000;
    end else if (wr_en && addr[7:0] == `MHX_ADDR_OPND) begin
      src0_q <= wr_data[15:0];
      src1_q <= wr_data[31:16];
    end
  end

  // Accumulators and their flags, one set per unit
  for (genvar u = 0; u < 2; u++) begin : g_unit
    logic hit;
    assign hit = cmd_wr && cmd_ok && unit == 1'(u);
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        acc_q[u] <= 40'h00_0000_0000;
      end else if (hit) begin
        acc_q[u] <= acc_new;
      end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        acc_ov_q[u] <= 1'b0;
      end else if (hit) begin
        acc_ov_q[u] <= acc_sat;
      end
    end
    // Set beats a software clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        acc_stk_q[u] <= 1'b0;
      end else if (hit && acc_sat) begin
        acc_stk_q[u] <= 1'b1;
      end else if (wr_en && addr[7:0] == `MHX_ADDR_STAT
        && wr_data[`MHX_ST_ACC_OV0 + 2 * u + 1]) begin
        acc_stk_q[u] <= 1'b0;
      end
    end
  end

  // Result overflow pair
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      res_ov_q <= 1'b0;
    end else if (cmd_wr && cmd_ok) begin
      res_ov_q <= xt.sat;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      res_stk_q <= 1'b0;
    end else if (cmd_wr && cmd_ok && xt.sat) begin
      res_stk_q <= 1'b1;
    end else if (wr_en && addr[7:0] == `MHX_ADDR_STAT
      && wr_data[`MHX_ST_RES_STK]) begin
      res_stk_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cmd_err_q <= 1'b0;
    end else if (cmd_wr && !cmd_ok) begin
      cmd_err_q <= 1'b1;
    end else if (wr_en && addr[7:0] == `MHX_ADDR_STAT
      && wr_data[`MHX_ST_CMD_ERR]) begin
      cmd_err_q <= 1'b0;
    end
  end

  // Rounding-mode bit lives in the status word, software owned
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rnd_bit_q <= 1'b0;
    end else if (wr_en && addr[7:0] == `MHX_ADDR_STAT) begin
      rnd_bit_q <= wr_data[`MHX_ST_RND];
    end
  end

  // A command changes only the addressed half and keeps the other; a DREG write replaces the whole word
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dreg_q <= 32'h0000_0000;
    end else if (cmd_wr && cmd_ok) begin
      if (half_hi) begin
        dreg_q[31:16] <= xt.half;
      end else begin
        dreg_q[15:0] <= xt.half;
      end
    end else if (wr_en && addr[7:0] == `MHX_ADDR_DREG) begin
      dreg_q <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= cmd_wr && cmd_ok;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data_q <= 32'h0000_0000;
    end else if (rd_en) begin
      unique case (addr[7:0])
        `MHX_ADDR_OPND: rd_data_q <= {src1_q, src0_q};
        `MHX_ADDR_STAT: rd_data_q <= {23'h00_0000, rnd_bit_q, 1'b0, cmd_err_q,
          acc_stk_q[1], acc_ov_q[1], acc_stk_q[0], acc_ov_q[0],
          res_stk_q, res_ov_q};
        `MHX_ADDR_DREG: rd_data_q <= dreg_q;
        `MHX_ADDR_ACC0_LO: rd_data_q <= acc_q[0][31:0];
        `MHX_ADDR_ACC0_HI: rd_data_q <= {24'h00_0000, acc_q[0][39:32]};
        `MHX_ADDR_ACC1_LO: rd_data_q <= acc_q[1][31:0];
        `MHX_ADDR_ACC1_HI: rd_data_q <= {24'h00_0000, acc_q[1][39:32]};
        default: rd_data_q <= 32'h0000_0000;
      endcase
    end else begin
      rd_data_q <= 32'h0000_0000;
    end
  end

  assign rd_data = rd_data_q;
  assign dreg_out = dreg_q;
  assign done_pulse = done_q;
endmodule

// ==== testbench/mhx_top_monitor.sv ====
`timescale 1ns/1ps
`include "mhx_cfg.svh"
module mhx_top_monitor #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys, // Core clock
  input wire logic reset, // Async reset
  input wire logic [ADDR_W-1:0] addr, // Byte address
  input wire logic [31:0] wr_data, // Write data
  input wire logic wr_en, // Write strobe
  input wire logic rd_en, // Read strobe
  input wire logic [31:0] rd_data, // Read data
  input wire logic [31:0] dreg_out, // Data register
  input wire logic done_pulse // Executed
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [31:0] opnd_q;
  logic rnd_q;
  wire logic cmd_wr = wr_en && addr == `MHX_ADDR_CMD;
  // Shadow copies, so results can be predicted from bus traffic alone
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      opnd_q <= 32'h0000_0000;
      rnd_q <= 1'b0;
    end else begin
      if (wr_en && addr == `MHX_ADDR_OPND) opnd_q <= wr_data;
      if (wr_en && addr == `MHX_ADDR_STAT) rnd_q <= wr_data[`MHX_ST_RND];
    end
  end
  wire logic signed [31:0] prod_ss = $signed(opnd_q[15:0]) * $signed(opnd_q[31:16]);
  wire logic signed [31:0] prod_su = $signed(opnd_q[15:0]) * $signed({1'b0, opnd_q[31:16]});
  wire logic [31:0] prod_uu = opnd_q[15:0] * opnd_q[31:16];
  wire logic [32:0] ih_r = {prod_ss[31], prod_ss}
    + ((rnd_q && prod_ss[16:0] == 17'h0_8000) ? 33'h0_0000_0000 : 33'h0_0000_8000);
  function automatic logic [15:0] sat17(input logic [16:0] x);
    return (x[16] != x[15]) ? (x[16] ? 16'h8000 : 16'h7FFF) : x[15:0];
  endfunction
  sequence load_cmd(logic [2:0] m, logic mx);
    cmd_wr && wr_data[2:0] == m && wr_data[3] == mx && wr_data[4] == mx
      && wr_data[7:5] == 3'h0 && wr_data[9:8] != 2'h3;
  endsequence
  tfu_extract_a: assert property (load_cmd(3'h1, 1'b0)
    |=> dreg_out[15:0] == prod_uu[31:16]) else $error("truncated extract wrong");
  frac_special_a: assert property (load_cmd(3'h2, 1'b0)
    ##0 (opnd_q == 32'h8000_8000) |=> dreg_out[15:0] == 16'h7FFF)
    else $error("special product not saturated");
  scaled_int_a: assert property (load_cmd(3'h3, 1'b0)
    |=> dreg_out[15:0] == sat17({prod_ss[15:0], 1'b0})) else $error("scaled int wrong");
  high_word_a: assert property (load_cmd(3'h4, 1'b0)
    |=> dreg_out[15:0] == sat17(ih_r[32:16])) else $error("high word wrong");
  mixed_int_a: assert property (load_cmd(3'h3, 1'b1)
    |=> dreg_out[15:0] == sat17({prod_su[15:0], 1'b0})) else $error("mixed wrong");
  other_half_a: assert property (cmd_wr && wr_data[7] ##1 done_pulse
    |-> dreg_out[15:0] == $past(dreg_out[15:0])) else $error("low half disturbed");
  mixed_unit0_a: assert property (cmd_wr && wr_data[3] && !wr_data[4]
    |=> !done_pulse && $stable(dreg_out)) else $error("mixed on unit 0 ran");
  pair_bad_a: assert property (cmd_wr && wr_data[9:8] == 2'h3
    |=> !done_pulse && $stable(dreg_out)) else $error("forbidden pairing ran");
endmodule

// ==== testbench/mhx_core_model.sv ====
`timescale 1ns/1ps
module mhx_core_model (
  input wire logic clk_sys, // Core clock
  output logic [7:0] addr, // Byte address
  output logic [31:0] wr_data, // Write data
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  input wire logic [31:0] rd_data // Read data
);
  initial begin
    addr = 8'hFF;
    wr_data = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    // Released data shows garbage, never the last word
    wr_data <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask
endmodule

// ==== testbench/mhx_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mhx_top_tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, dreg_out, dr;
  logic wr_en, rd_en, done_pulse;
  logic [8:0] st;
  longint acc[2];
  int err_total = 0;
  int checks_done = 0;
  integer seed = 32'hC932_3818;
  always #25 clk_sys = ~clk_sys;
  mhx_top #(.ADDR_W(8)) u_mhx_top (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .dreg_out(dreg_out), .done_pulse(done_pulse));
  mhx_core_model core (.clk_sys(clk_sys), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data));
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check_state;
    logic [31:0] d;
    core.rd(8'h08, d);
    `CHK(d, {23'h0, st})
    for (int i = 0; i < 2; i++) begin
      core.rd(8'(8'h10 + 8 * i), d);
      `CHK(d, acc[i][31:0])
      core.rd(8'(8'h14 + 8 * i), d);
      `CHK(d, {24'h00_0000, acc[i][39:32]})
    end
  endtask
  task automatic setst(input logic [31:0] d);
    core.wr(8'h08, d);
    st = st & ~(d[8:0] & 9'h06A);
    st[8] = d[8];
  endtask
  task automatic cmd(input int m, x, u, o, h, pr, input logic [31:0] op);
    longint a, b, p, v, lo, hi;
    logic s, ao;
    a = (m == 1) ? longint'(op[15:0]) : longint'($signed(op[15:0]));
    b = (m == 1 || x) ? longint'(op[31:16]) : longint'($signed(op[31:16]));
    p = a * b;
    ao = 0;
    if ((m == 0 || m == 2) && !x) begin
      ao = (p == 64'h4000_0000);
      p = ao ? 64'h7FFF_FFFF : 2 * p;
    end
    v = (o == 0) ? p : (o == 1) ? acc[u] + p : acc[u] - p;
    hi = (m == 1) ? 64'hFF_FFFF_FFFF : (m == 4) ? 64'h7FFF_FFFF : 64'h7F_FFFF_FFFF;
    lo = (m == 1) ? 0 : -hi - 1;
    ao |= (v > hi || v < lo);
    v = (v > hi) ? hi : (v < lo) ? lo : v;
    acc[u] = v;
    if (m == 1) v = v >>> 16;
    else if (m == 3) v = 2 * longint'($signed(v[15:0]));
    else begin
      if (m == 2) v = 2 * v;
      if (!(st[8] && v[16:0] == 17'h0_8000)) v = v + 64'h8000;
      v = v >>> 16;
    end
    hi = (m == 1) ? 64'hFFFF : 64'h7FFF;
    lo = (m == 1) ? 0 : -hi - 1;
    s = (v > hi || v < lo);
    v = (v > hi) ? hi : (v < lo) ? lo : v;
    dr = h ? {v[15:0], dr[15:0]} : {dr[31:16], v[15:0]};
    st[0] = s;
    st[1] |= s;
    st[2 + 2 * u] = ao;
    st[3 + 2 * u] |= ao;
    core.wr(8'h00, op);
    core.wr(8'h04, {22'h0, pr[1:0], h[0], o[1:0], u[0], x[0], m[2:0]});
    `CHK(done_pulse, 1'b1)
    `CHK(dreg_out, dr)
    check_state();
  endtask
  task automatic refuse(input logic [31:0] w);
    core.wr(8'h04, w);
    `CHK(done_pulse, 1'b0)
    `CHK(dreg_out, dr)
    st[6] = 1'b1;
    check_state();
  endtask
  initial begin
    logic [31:0] r;
    int u;
    acc[0] = 0;
    acc[1] = 0;
    dr = 32'h0000_0000;
    st = 9'h000;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    check_state();
    `CHK(dreg_out, 32'h0000_0000)
    cmd(1, 0, 0, 0, 0, 0, 32'h8000_8000);
    cmd(2, 0, 0, 0, 0, 1, 32'h8000_8000);
    cmd(0, 0, 1, 0, 1, 2, 32'h4000_0001);
    setst(32'h0000_0100);
    cmd(0, 0, 1, 0, 1, 0, 32'h4000_0001);
    cmd(4, 0, 0, 0, 0, 0, 32'h4000_0002);
    cmd(3, 0, 0, 0, 0, 0, 32'h0001_7FFF);
    cmd(3, 1, 1, 0, 0, 0, 32'hFFFF_8000);
    cmd(4, 0, 1, 0, 1, 0, 32'h7FFF_7FFF);
    repeat (2) cmd(4, 0, 1, 1, 1, 0, 32'h7FFF_7FFF);
    cmd(1, 0, 0, 0, 0, 0, 32'h0001_0001);
    repeat (2) cmd(1, 0, 0, 2, 1, 0, 32'hFFFF_FFFF);
    core.wr(8'h0C, 32'hA5C3_5A3C);
    dr = 32'hA5C3_5A3C;
    `CHK(dreg_out, dr)
    core.rd(8'h0C, r);
    `CHK(r, dr)
    core.rd(8'h00, r);
    `CHK(r, 32'hFFFF_FFFF)
    core.rd(8'h04, r);
    `CHK(r, 32'h0000_0000)
    core.wr(8'h10, 32'h1234_5678);
    check_state();
    setst(32'h0000_006A);
    refuse(32'h0000_0008);
    refuse(32'h0000_0300);
    refuse(32'h0000_0060);
    refuse(32'h0000_0005);
    for (int m = 0; m < 5; m++) begin
      for (int k = 0; k < 12; k++) begin
        r = $random(seed);
        u = (k < 2) ? k : r[4];
        cmd(m, (m != 1) & u & r[3], u, (k < 2) ? 0 : r[6:5] % 3, r[7], r[9:8] % 3,
          $random(seed));
        if (k == 6) setst({23'h0, r[10], 8'h00});
      end
    end
    final_report();
  end
  initial begin
    #500000;
    err_total++;
    final_report();
  end
endmodule
bind mhx_top mhx_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk_sys(clk_sys), .reset(reset),
  .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .dreg_out(dreg_out), .done_pulse(done_pulse));
